// >>> hw/tpdl_device_end.sv
// Transceiver end: samples the DDR lanes and assembles channel words
`timescale 1ns/1ps
// Notes on behaviour
// - Lanes carry data on both clock edges.
// - Multiplexed: odd channel rising, even channel falling.
// - Nibble: upper nibble rising, lower nibble falling.
// - Nibble: bits 4..0 even, 9..5 odd.
// - Word bit 0 is first serial bit.
// - Multiplexed with encoder: bit 8 marks K.
// - Multiplexed, no encoder: bit 8 is ninth bit.
// - Nibble, no encoder: bit 8 gives bits 3, 8.
// - Nibble with encoder: rising bit 8 is odd K, falling bit 8 is odd bit 3.
// - Nibble with encoder: rising lane bit 3 even K, falling lane bit 3 even bit 3.
// - Bit 9 is tenth bit; low with encoder, except on the nibble fall, which carries odd bit 4.
// - Independent: G/H lanes use own pair clock.
// - Independent: C/D lanes use own pair clock.
// - Independent: E/F lanes use own pair clock.
// - Otherwise all pairs use the shared clock.
module tpdl_device_end (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Link pins
	tpdl_link_if.dev link,
	// Assembled channel words C..H, index 0..5
	output logic [tpdl_pkg::NUM_CH-1:0][tpdl_pkg::WORD_W-1:0] ch_word,
	output logic [tpdl_pkg::NUM_CH-1:0] ch_kchar,
	output logic [tpdl_pkg::NUM_CH-1:0] ch_valid
);
	import tpdl_pkg::*;

	// Stage [0] of each synchroniser feeds only stage [1]
	typedef struct packed {
		logic [1:0][NUM_CLKS-1:0] clk_sync;
		logic [1:0][NUM_PAIRS-1:0][WORD_W-1:0] lane_sync;
		logic [1:0][MODE_W-1:0] mode_sync;
		logic [1:0] code_sync;
		logic [NUM_PAIRS-1:0] clk_prev;
		logic [NUM_PAIRS-1:0][WORD_W-1:0] rise_hold;
		logic [NUM_PAIRS-1:0] rise_seen;
		logic [NUM_CH-1:0][WORD_W-1:0] word;
		logic [NUM_CH-1:0] kchar;
		logic [NUM_CH-1:0] valid;
	} tpdl_dev_state_s;

	tpdl_dev_state_s s;
	tpdl_dev_state_s next_s;

	always_comb begin
		logic [MODE_W-1:0] mode;
		logic code;
		logic sel_clk;
		logic rise;
		logic fall;
		logic [WORD_W-1:0] pins;
		logic [WORD_W-1:0] even_raw;
		logic [WORD_W-1:0] odd_raw;
		logic [WORD_W:0] dec;
		mode = '0;
		code = 1'b0;
		sel_clk = 1'b0;
		rise = 1'b0;
		fall = 1'b0;
		pins = '0;
		even_raw = '0;
		odd_raw = '0;
		dec = '0;

		next_s = s;
		next_s.valid = '0;

		// Clock pins are sampled like data, so both see equal latency
		next_s.clk_sync[0] = {link.pair_gh_tx_clock, link.pair_ef_tx_clock,
			link.pair_cd_tx_clock, link.shared_tx_clock};
		next_s.clk_sync[1] = s.clk_sync[0];
		next_s.lane_sync[0][0] = {link.pair_cd_bit9_lane,
			link.pair_cd_bit8_lane, link.pair_cd_tx_lanes};
		next_s.lane_sync[0][1] = {link.pair_ef_bit9_lane,
			link.pair_ef_bit8_lane, link.pair_ef_tx_lanes};
		next_s.lane_sync[0][2] = {link.pair_gh_bit9_lane,
			link.pair_gh_bit8_lane, link.pair_gh_tx_lanes};
		next_s.lane_sync[1] = s.lane_sync[0];
		next_s.mode_sync[0] = link.arrangement;
		next_s.mode_sync[1] = s.mode_sync[0];
		next_s.code_sync[0] = link.encoder_sel;
		next_s.code_sync[1] = s.code_sync[0];

		mode = s.mode_sync[1];
		code = s.code_sync[1];

		for (int p = 0; p < NUM_PAIRS; p++) begin
			// Pair p owns clock index p+1 in independent arrangement
			if (mode == MODE_INDEP) begin
				sel_clk = s.clk_sync[1][p+1];
			end else begin
				sel_clk = s.clk_sync[1][SHARED_CLK_IDX];
			end
			next_s.clk_prev[p] = sel_clk;
			rise = sel_clk & ~s.clk_prev[p];
			fall = ~sel_clk & s.clk_prev[p];
			pins = s.lane_sync[1][p];

			if (mode == MODE_NIBBLE) begin
				if (rise) begin
					next_s.rise_hold[p] = pins;
					next_s.rise_seen[p] = 1'b1;
				end
				// A falling edge with no rising half before it is dropped
				if (fall && s.rise_seen[p]) begin
					next_s.rise_seen[p] = 1'b0;
					even_raw = {s.rise_hold[p][NIB_EVEN_LSB +: FIELD_W],
						pins[NIB_EVEN_LSB +: FIELD_W]};
					odd_raw = {s.rise_hold[p][NIB_ODD_LSB +: FIELD_W],
						pins[NIB_ODD_LSB +: FIELD_W]};
					// Bit 8 of each word is the rising lane bit 3 or bit 8
					dec = tpdl_decode(even_raw, code);
					next_s.word[2*p] = dec[WORD_W-1:0];
					next_s.kchar[2*p] = dec[WORD_W];
					next_s.valid[2*p] = 1'b1;
					dec = tpdl_decode(odd_raw, code);
					next_s.word[2*p+1] = dec[WORD_W-1:0];
					next_s.kchar[2*p+1] = dec[WORD_W];
					next_s.valid[2*p+1] = 1'b1;
				end
			end else begin
				next_s.rise_seen[p] = 1'b0;
				// Pins map straight to {bit9, bit8, lanes}, bit 0 first out
				dec = tpdl_decode(pins, code);
				if (rise) begin
					next_s.word[2*p+1] = dec[WORD_W-1:0];
					next_s.kchar[2*p+1] = dec[WORD_W];
					next_s.valid[2*p+1] = 1'b1;
				end
				if (fall) begin
					next_s.word[2*p] = dec[WORD_W-1:0];
					next_s.kchar[2*p] = dec[WORD_W];
					next_s.valid[2*p] = 1'b1;
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign ch_word = s.word;
	assign ch_kchar = s.kchar;
	assign ch_valid = s.valid;

endmodule : tpdl_device_end

// >>> hw/tpdl_pkg.sv
// Shared constants and types for the parallel DDR transmit lane link
package tpdl_pkg;

	// Lane structure
	localparam int NUM_PAIRS = 3;
	localparam int NUM_CH = 6;
	localparam int LANE_W = 8;
	localparam int WORD_W = 10;
	localparam int FIELD_W = 5;
	localparam int MODE_W = 3;

	// Field positions inside a 10-bit pair word {bit9, bit8, lanes[7:0]}
	localparam int BIT8_POS = 8;
	localparam int BIT9_POS = 9;
	localparam int NIB_EVEN_LSB = 0;
	localparam int NIB_ODD_LSB = 5;

	// Clock index in the clock sample vector: 0 shared, 1..3 pairs C/D..G/H
	localparam int SHARED_CLK_IDX = 0;
	localparam int NUM_CLKS = 4;

	// Interface arrangements, one-hot
	typedef enum logic [MODE_W-1:0] {
		MODE_MUX = 3'h1,
		MODE_NIBBLE = 3'h2,
		MODE_INDEP = 3'h4
	} tpdl_mode_e;

	// Timing of the link clock made by the protocol-device end
	localparam int CLK_PERIOD_NS = 50;
	localparam int LINK_PERIOD_NS = 400;
	localparam int LINK_HALF_CYC = LINK_PERIOD_NS / CLK_PERIOD_NS / 2;

	// Reset values
	localparam logic [WORD_W-1:0] WORD_RESET = 10'h000;

	// Raw 10-bit word to {kchar, word}: with the encoder, K rides in bit 8
	function automatic logic [WORD_W:0] tpdl_decode(
		input logic [WORD_W-1:0] raw,
		input logic encoder_sel
	);
		if (encoder_sel) begin
			tpdl_decode = {raw[BIT8_POS], 2'h0, raw[LANE_W-1:0]};
		end else begin
			tpdl_decode = {1'b0, raw};
		end
	endfunction : tpdl_decode

endpackage : tpdl_pkg

// >>> hw/tpdl_link_if.sv
// Pin-level link between the protocol device and the transceiver input
`timescale 1ns/1ps
interface tpdl_link_if;
	import tpdl_pkg::*;

	logic shared_tx_clock;
	logic pair_cd_tx_clock;
	logic pair_ef_tx_clock;
	logic pair_gh_tx_clock;
	logic [LANE_W-1:0] pair_cd_tx_lanes;
	logic pair_cd_bit8_lane;
	logic pair_cd_bit9_lane;
	logic [LANE_W-1:0] pair_ef_tx_lanes;
	logic pair_ef_bit8_lane;
	logic pair_ef_bit9_lane;
	logic [LANE_W-1:0] pair_gh_tx_lanes;
	logic pair_gh_bit8_lane;
	logic pair_gh_bit9_lane;
	logic [MODE_W-1:0] arrangement;
	logic encoder_sel;

	modport dev (
		input shared_tx_clock, pair_cd_tx_clock, pair_ef_tx_clock,
		input pair_gh_tx_clock,
		input pair_cd_tx_lanes, pair_cd_bit8_lane, pair_cd_bit9_lane,
		input pair_ef_tx_lanes, pair_ef_bit8_lane, pair_ef_bit9_lane,
		input pair_gh_tx_lanes, pair_gh_bit8_lane, pair_gh_bit9_lane,
		input arrangement, encoder_sel
	);

	modport host (
		output shared_tx_clock, pair_cd_tx_clock, pair_ef_tx_clock,
		output pair_gh_tx_clock,
		output pair_cd_tx_lanes, pair_cd_bit8_lane, pair_cd_bit9_lane,
		output pair_ef_tx_lanes, pair_ef_bit8_lane, pair_ef_bit9_lane,
		output pair_gh_tx_lanes, pair_gh_bit8_lane, pair_gh_bit9_lane,
		output arrangement, encoder_sel
	);

endinterface : tpdl_link_if

// >>> hw/tpdl_host_end.sv
// Protocol-device end: makes the link clock and drives DDR lane data
`timescale 1ns/1ps
module tpdl_host_end #(
	parameter int HALF_CYC = tpdl_pkg::LINK_HALF_CYC
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Link pins
	tpdl_link_if.host link,
	// Configuration, taken once per link period
	input wire logic [tpdl_pkg::MODE_W-1:0] cfg_arrangement,
	input wire logic cfg_encoder_sel,
	// Channel words C..H, index 0..5
	input wire logic [tpdl_pkg::NUM_CH-1:0][tpdl_pkg::WORD_W-1:0] ch_word_in,
	input wire logic [tpdl_pkg::NUM_CH-1:0] ch_kchar_in,
	output logic word_taken
);
	import tpdl_pkg::*;

	localparam int PERIOD = 2 * HALF_CYC;
	localparam int CNT_W = $clog2(PERIOD);
	localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(PERIOD - 1);
	localparam logic [CNT_W-1:0] CNT_RISE_DATA = CNT_W'(0);
	localparam logic [CNT_W-1:0] CNT_RISE_EDGE = CNT_W'(HALF_CYC / 2);
	localparam logic [CNT_W-1:0] CNT_FALL_DATA = CNT_W'(HALF_CYC);
	localparam logic [CNT_W-1:0] CNT_FALL_EDGE = CNT_W'(HALF_CYC + HALF_CYC / 2);

	typedef struct packed {
		logic [CNT_W-1:0] cnt;
		logic [NUM_CH-1:0][WORD_W-1:0] word;
		logic [NUM_CH-1:0] kchar;
		logic [MODE_W-1:0] mode;
		logic code;
		logic link_clk;
		logic [NUM_PAIRS-1:0][WORD_W-1:0] pins;
		logic taken;
	} tpdl_host_state_s;

	tpdl_host_state_s s;
	tpdl_host_state_s next_s;

	// Pin pattern of one pair for one edge
	function automatic logic [WORD_W-1:0] pair_pins(
		input logic [MODE_W-1:0] mode,
		input logic code,
		input logic [WORD_W-1:0] even_w,
		input logic even_k,
		input logic [WORD_W-1:0] odd_w,
		input logic odd_k,
		input logic rising
	);
		logic [WORD_W-1:0] ew;
		logic [WORD_W-1:0] ow;
		ew = code ? {1'b0, even_k, even_w[LANE_W-1:0]} : even_w;
		ow = code ? {1'b0, odd_k, odd_w[LANE_W-1:0]} : odd_w;
		if (mode == MODE_NIBBLE) begin
			// Upper half of each word goes first, on the rising edge
			if (rising) begin
				pair_pins = {ow[9:5], ew[9:5]};
			end else begin
				pair_pins = {ow[4:0], ew[4:0]};
			end
		end else begin
			pair_pins = rising ? ow : ew;
		end
	endfunction : pair_pins

	always_comb begin
		next_s = s;
		next_s.taken = 1'b0;
		next_s.cnt = (s.cnt == CNT_LAST) ? '0 : s.cnt + 1'b1;
		// Config and words only change between periods
		if (s.cnt == CNT_LAST) begin
			next_s.word = ch_word_in;
			next_s.kchar = ch_kchar_in;
			next_s.mode = cfg_arrangement;
			next_s.code = cfg_encoder_sel;
			next_s.taken = 1'b1;
		end
		// Data is set up half a half-period ahead of each edge
		if (s.cnt == CNT_RISE_EDGE) begin
			next_s.link_clk = 1'b1;
		end
		if (s.cnt == CNT_FALL_EDGE) begin
			next_s.link_clk = 1'b0;
		end
		for (int p = 0; p < NUM_PAIRS; p++) begin
			if (s.cnt == CNT_RISE_DATA || s.cnt == CNT_FALL_DATA) begin
				next_s.pins[p] = pair_pins(s.mode, s.code,
					s.word[2*p], s.kchar[2*p],
					s.word[2*p+1], s.kchar[2*p+1],
					s.cnt == CNT_RISE_DATA);
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	// One divider feeds every clock pin, so any arrangement is served
	assign link.shared_tx_clock = s.link_clk;
	assign link.pair_cd_tx_clock = s.link_clk;
	assign link.pair_ef_tx_clock = s.link_clk;
	assign link.pair_gh_tx_clock = s.link_clk;
	assign link.pair_cd_tx_lanes = s.pins[0][LANE_W-1:0];
	assign link.pair_cd_bit8_lane = s.pins[0][BIT8_POS];
	assign link.pair_cd_bit9_lane = s.pins[0][BIT9_POS];
	assign link.pair_ef_tx_lanes = s.pins[1][LANE_W-1:0];
	assign link.pair_ef_bit8_lane = s.pins[1][BIT8_POS];
	assign link.pair_ef_bit9_lane = s.pins[1][BIT9_POS];
	assign link.pair_gh_tx_lanes = s.pins[2][LANE_W-1:0];
	assign link.pair_gh_bit8_lane = s.pins[2][BIT8_POS];
	assign link.pair_gh_bit9_lane = s.pins[2][BIT9_POS];
	assign link.arrangement = s.mode;
	assign link.encoder_sel = s.code;
	assign word_taken = s.taken;

endmodule : tpdl_host_end

// >>> dv/tpdl_link_props.sv
// Link-pin checker for the parallel DDR transmit lane link
`timescale 1ns/1ps
module tpdl_link_props
	import tpdl_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Link pins
	input wire logic shared_tx_clock,
	input wire logic pair_cd_tx_clock,
	input wire logic pair_ef_tx_clock,
	input wire logic pair_gh_tx_clock,
	input wire logic [LANE_W-1:0] pair_cd_tx_lanes,
	input wire logic pair_cd_bit8_lane,
	input wire logic pair_cd_bit9_lane,
	input wire logic [LANE_W-1:0] pair_ef_tx_lanes,
	input wire logic pair_ef_bit8_lane,
	input wire logic pair_ef_bit9_lane,
	input wire logic [LANE_W-1:0] pair_gh_tx_lanes,
	input wire logic pair_gh_bit8_lane,
	input wire logic pair_gh_bit9_lane,
	input wire logic [MODE_W-1:0] arrangement,
	input wire logic encoder_sel
);
	logic [29:0] lanes;
	logic [2:0] tenth;
	assign lanes = {pair_cd_bit9_lane, pair_cd_bit8_lane, pair_cd_tx_lanes,
		pair_ef_bit9_lane, pair_ef_bit8_lane, pair_ef_tx_lanes,
		pair_gh_bit9_lane, pair_gh_bit8_lane, pair_gh_tx_lanes};
	assign tenth = {pair_cd_bit9_lane, pair_ef_bit9_lane, pair_gh_bit9_lane};
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	sequence s_high;
		shared_tx_clock [*4];
	endsequence
	sequence s_low;
		!shared_tx_clock [*4];
	endsequence
	AST_CLK_PERIOD: assert property (
		$rose(shared_tx_clock) |-> s_high ##1 s_low ##1 shared_tx_clock)
		else $error("link clock period wrong");
	AST_SETUP: assert property (
		$changed(lanes) |-> $stable(shared_tx_clock) [*2])
		else $error("lane data too close before clock edge");
	AST_HOLD: assert property (
		$changed(shared_tx_clock) |-> $stable(lanes) [*2])
		else $error("lane data too close after clock edge");
	AST_PAIR_CLK: assert property (
		pair_cd_tx_clock == shared_tx_clock
		&& pair_ef_tx_clock == shared_tx_clock
		&& pair_gh_tx_clock == shared_tx_clock)
		else $error("pair clock differs from shared clock");
	AST_CFG_GAP: assert property (
		$changed({arrangement, encoder_sel}) |->
		!shared_tx_clock ##1 !shared_tx_clock)
		else $error("configuration changed near a clock edge");
	AST_CFG_HOLD: assert property (
		$changed({arrangement, encoder_sel}) |=>
		$stable({arrangement, encoder_sel}) [*7])
		else $error("configuration changed within a period");
	AST_TENTH_RISE: assert property (
		encoder_sel && $rose(shared_tx_clock) |-> tenth == 3'h0)
		else $error("tenth-bit lane high on rise with encoder");
	AST_TENTH_MUX: assert property (
		encoder_sel && arrangement == MODE_MUX && $fell(shared_tx_clock)
		|-> tenth == 3'h0)
		else $error("tenth-bit lane high on fall with encoder");
endmodule : tpdl_link_props

// >>> dv/tpdl_tb_top.sv
// Self-checking bench for the parallel DDR transmit lane link
`timescale 1ns/1ps
module tpdl_tb_top;
	import tpdl_pkg::*;
	localparam logic [MODE_W-1:0] MODES [3] = '{MODE_MUX, MODE_NIBBLE,
		MODE_INDEP};
	logic clk, rst, cfg_enc, word_taken;
	logic [MODE_W-1:0] cfg_arr;
	logic [NUM_CH-1:0][WORD_W-1:0] w_in, ch_word;
	logic [NUM_CH-1:0] k_in, ch_kchar, ch_valid;
	int errors, samples_checked;
	tpdl_link_if link ();
	tpdl_host_end i_tpdl_host_end (.clk(clk), .rst(rst), .link(link),
		.cfg_arrangement(cfg_arr), .cfg_encoder_sel(cfg_enc),
		.ch_word_in(w_in), .ch_kchar_in(k_in), .word_taken(word_taken));
	tpdl_device_end i_tpdl_device_end (.clk(clk), .rst(rst), .link(link),
		.ch_word(ch_word), .ch_kchar(ch_kchar), .ch_valid(ch_valid));
	tpdl_link_props i_tpdl_link_props (.clk(clk), .rst(rst),
		.shared_tx_clock(link.shared_tx_clock),
		.pair_cd_tx_clock(link.pair_cd_tx_clock),
		.pair_ef_tx_clock(link.pair_ef_tx_clock),
		.pair_gh_tx_clock(link.pair_gh_tx_clock),
		.pair_cd_tx_lanes(link.pair_cd_tx_lanes),
		.pair_cd_bit8_lane(link.pair_cd_bit8_lane),
		.pair_cd_bit9_lane(link.pair_cd_bit9_lane),
		.pair_ef_tx_lanes(link.pair_ef_tx_lanes),
		.pair_ef_bit8_lane(link.pair_ef_bit8_lane),
		.pair_ef_bit9_lane(link.pair_ef_bit9_lane),
		.pair_gh_tx_lanes(link.pair_gh_tx_lanes),
		.pair_gh_bit8_lane(link.pair_gh_bit8_lane),
		.pair_gh_bit9_lane(link.pair_gh_bit9_lane),
		.arrangement(link.arrangement), .encoder_sel(link.encoder_sel));
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	task automatic final_report();
		$display("checked %0d mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : final_report
	task automatic check(input string what, input logic [WORD_W-1:0] seen,
		input logic [WORD_W-1:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	function automatic logic [WORD_W-1:0] raw(input int c);
		raw = cfg_enc ? {1'b0, k_in[c], w_in[c][7:0]} : w_in[c];
	endfunction : raw
	function automatic logic [WORD_W-1:0] pins(input int p);
		case (p)
			0: pins = {link.pair_cd_bit9_lane, link.pair_cd_bit8_lane,
				link.pair_cd_tx_lanes};
			1: pins = {link.pair_ef_bit9_lane, link.pair_ef_bit8_lane,
				link.pair_ef_tx_lanes};
			default: pins = {link.pair_gh_bit9_lane, link.pair_gh_bit8_lane,
				link.pair_gh_tx_lanes};
		endcase
	endfunction : pins
	// Bounded wait for the host's sample pulse, landing just after its edge
	task automatic wait_taken();
		int t;
		t = 0;
		do begin
			@(posedge clk);
			#1;
			t++;
		end while (word_taken !== 1'b1 && t < 20);
		if (t >= 20) errors++;
	endtask : wait_taken
	task automatic run(input logic [MODE_W-1:0] m, input logic e, input int n);
		logic [WORD_W-1:0] rise [3];
		logic [WORD_W-1:0] ev, od;
		logic nib;
		nib = (m == MODE_NIBBLE);
		@(posedge clk);
		cfg_arr <= m;
		cfg_enc <= e;
		for (int c = 0; c < NUM_CH; c++) begin
			w_in[c] <= WORD_W'(37 * (n * 6 + c) + 10'h155);
			k_in[c] <= c[0] ^ n[0];
		end
		// Second pulse: the first may have sampled the old inputs
		wait_taken();
		wait_taken();
		// Rising-edge data is registered one cycle after the sample pulse
		@(posedge clk);
		#1;
		for (int p = 0; p < 3; p++) rise[p] = pins(p);
		repeat (4) @(posedge clk);
		#1;
		for (int p = 0; p < 3; p++) begin
			ev = raw(2 * p);
			od = raw(2 * p + 1);
			check("rise", rise[p], nib ? {od[9:5], ev[9:5]} : od);
			check("fall", pins(p), nib ? {od[4:0], ev[4:0]} : ev);
		end
		repeat (5) @(posedge clk);
		#1;
		check("valid", WORD_W'(ch_valid), nib ? 10'h03f : 10'h015);
		@(posedge clk);
		#1;
		for (int c = 0; c < NUM_CH; c++) begin
			check("word", ch_word[c], e ? {2'h0, w_in[c][7:0]} : w_in[c]);
			check("kchar", WORD_W'(ch_kchar[c]), WORD_W'(e & k_in[c]));
		end
		$display("test %0d mode %h encoder %b done", n, m, e);
	endtask : run
	initial begin
		errors = 0;
		samples_checked = 0;
		rst = 1'b1;
		cfg_arr = MODE_MUX;
		cfg_enc = 1'b0;
		w_in = '0;
		k_in = '0;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		for (int n = 0; n < 6; n++) run(MODES[n % 3], 1'(n / 3), n);
		final_report();
	end
	initial begin
		#50000;
		errors++;
		final_report();
	end
endmodule : tpdl_tb_top
